// file: sswd_cfg.svh
/*
  constants for the synchronous sram write decode and output drive block.
  assumes inclusion by bare name from the package and the design file.
*/
`ifndef SSWD_CFG_SVH
`define SSWD_CFG_SVH
`define SSWD_LANES 4
`define SSWD_LANE_BITS 8
`define SSWD_ADDR_BITS 17
`define SSWD_BURST_BITS 2
`define SSWD_SLEEP_CYCLES 2
`define SSWD_LANES_IDLE 4'h0
`define SSWD_LANES_ALL 4'hF
`endif

// file: sswd_pkg.sv
/*
  types shared by the sram write decode block.
  assumes sswd_cfg.svh is on the include path.
*/
`include "sswd_cfg.svh"
package sswd_pkg;
  typedef logic [`SSWD_LANES-1:0] sswd_lane_t;
  typedef logic [`SSWD_LANE_BITS:0] sswd_byte_t;
  typedef enum logic [1:0] {
    SSWD_IDLE = 2'b00,
    SSWD_READ = 2'b01,
    SSWD_WRITE = 2'b11,
    SSWD_SLEEP = 2'b10
  } sswd_cyc_e;
endpackage : sswd_pkg

// file: sswd_core.sv
/*
  write decode, burst sequencing and output drive of a pipelined burst sram, with its own storage.
  assumes all inputs are synchronous to clk_in except out_enable_n_in and sleep_request_in.
*/
// Behaviour
// - write when global or gated lane strobe low
// - read when all write strobes inactive
// - gated write only lanes whose enables are low; global write all lanes
// - proc strobe forces read, write strobes ignored
// - writes follow proc strobe or ctrl strobe
// - output enable combinational, masked during writes
// - drive pins on read with enable low
// - advance low steps burst, high holds
// - mode high interleaved, grounded linear order
// - sleep entered within two cycles
`timescale 1ns/1ps
`include "sswd_cfg.svh"
module sswd_core
  import sswd_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // address and strobes
  input wire logic [`SSWD_ADDR_BITS-1:0] addr_in,
  input wire logic chip_select_n_in,
  input wire logic proc_addr_strobe_n_in,
  input wire logic ctrl_addr_strobe_n_in,
  input wire logic burst_advance_n_in,
  input wire logic burst_mode_in,
  input wire logic sleep_request_in,
  // write strobes and output enable
  input wire logic global_write_n_in,
  input wire logic byte_write_gate_n_in,
  input wire logic lane_a_write_n_in,
  input wire logic lane_b_write_n_in,
  input wire logic lane_c_write_n_in,
  input wire logic lane_d_write_n_in,
  input wire logic out_enable_n_in,
  // data pins, per lane 8 data bits plus lane_parity_bit on top
  input wire logic [`SSWD_LANES*(`SSWD_LANE_BITS+1)-1:0] data_in,
  output logic [`SSWD_LANES*(`SSWD_LANE_BITS+1)-1:0] data_out,
  output logic [`SSWD_LANES*(`SSWD_LANE_BITS+1)-1:0] data_oe_n_out,
  // status
  output logic [`SSWD_LANES-1:0] lane_write_out,
  output logic sleeping_out
);
  localparam int W = `SSWD_LANE_BITS + 1;
  localparam int DEPTH = 1 << `SSWD_ADDR_BITS;

  // a pending access is dropped: sleep clears the burst and blocks new starts
  // sleep request resynchronised; two flops give the two cycle entry
  logic sleep_meta_q;
  logic sleep_q;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sleep_meta_q <= 1'b0;
      sleep_q <= 1'b0;
    end else begin
      sleep_meta_q <= sleep_request_in;
      sleep_q <= sleep_meta_q;
    end
  end

  // cycle type decode
  sswd_lane_t lane_n;
  logic active_q; // a burst is open; set by any start, cleared by sleep
  wire logic proc_start = !proc_addr_strobe_n_in && !chip_select_n_in;
  wire logic ctrl_start = proc_addr_strobe_n_in && !ctrl_addr_strobe_n_in && !chip_select_n_in;
  wire logic cont = proc_addr_strobe_n_in && ctrl_addr_strobe_n_in;
  assign lane_n = {lane_d_write_n_in, lane_c_write_n_in, lane_b_write_n_in, lane_a_write_n_in};
  wire logic write_req = !global_write_n_in || (!byte_write_gate_n_in && (lane_n != `SSWD_LANES_ALL));
  wire sswd_lane_t lanes_req = !global_write_n_in ? `SSWD_LANES_ALL :
                               (!byte_write_gate_n_in ? ~lane_n : `SSWD_LANES_IDLE);
  // proc strobe start is always a read; writes only on ctrl start or continuation
  // chip select is not looked at on continuation, so a burst outlives a deselect
  wire logic do_write = !sleep_q && !proc_start && (ctrl_start || (cont && active_q)) && write_req;
  wire sswd_lane_t lanes_wr = do_write ? lanes_req : `SSWD_LANES_IDLE;

  // burst state
  sswd_cyc_e cyc_q;
  sswd_cyc_e cyc_d;
  logic [`SSWD_ADDR_BITS-1:0] base_q;
  logic [`SSWD_BURST_BITS-1:0] cnt_q;
  logic [`SSWD_BURST_BITS-1:0] cnt_d;
  wire logic start = (proc_start || ctrl_start) && !sleep_q;
  assign cnt_d = start ? `SSWD_BURST_BITS'(0) :
                 ((cont && !burst_advance_n_in) ? cnt_q + `SSWD_BURST_BITS'(1) : cnt_q);
  wire logic [`SSWD_BURST_BITS-1:0] low_base = base_q[`SSWD_BURST_BITS-1:0];
  wire logic [`SSWD_BURST_BITS-1:0] low_addr = burst_mode_in ? (low_base ^ cnt_q) : (low_base + cnt_q);
  wire logic [`SSWD_ADDR_BITS-1:0] cur_addr = start ? addr_in :
                                              {base_q[`SSWD_ADDR_BITS-1:`SSWD_BURST_BITS], low_addr};
  wire logic [`SSWD_ADDR_BITS-1:0] nxt_base = start ? addr_in : base_q;
  wire logic [`SSWD_BURST_BITS-1:0] nxt_low = burst_mode_in ? (nxt_base[1:0] ^ cnt_d) : (nxt_base[1:0] + cnt_d);
  wire logic [`SSWD_ADDR_BITS-1:0] rd_addr = {nxt_base[`SSWD_ADDR_BITS-1:`SSWD_BURST_BITS], nxt_low};

  // next cycle type
  always_comb begin
    cyc_d = cyc_q;
    case (1'b1)
      sleep_q: cyc_d = SSWD_SLEEP;
      do_write: cyc_d = SSWD_WRITE;
      start: cyc_d = SSWD_READ;
      (cont && active_q): cyc_d = SSWD_READ;
      default: cyc_d = SSWD_IDLE;
    endcase
  end

  // burst registers
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cyc_q <= SSWD_IDLE;
      active_q <= 1'b0;
      base_q <= '0;
      cnt_q <= '0;
    end else begin
      cyc_q <= cyc_d;
      active_q <= sleep_q ? 1'b0 : (start ? 1'b1 : active_q);
      base_q <= nxt_base;
      cnt_q <= cnt_d;
    end
  end

  // storage, one generate per lane including its parity bit
  // no reset on storage: words never written read back unknown
  logic [`SSWD_LANES*W-1:0] rd_q;
  genvar g;
  generate
    for (g = 0; g < `SSWD_LANES; g++) begin : g_lane
      logic [W-1:0] mem_q [DEPTH];
      always_ff @(posedge clk_in) begin
        if (lanes_wr[g]) begin
          mem_q[cur_addr] <= data_in[g*W +: W];
        end
      end
      always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          rd_q[g*W +: W] <= '0;
        end else begin
          rd_q[g*W +: W] <= mem_q[rd_addr];
        end
      end
    end
  endgenerate

  // pin drive; output enable acts without the clock and is masked in writes
  // the mask covers the cycle after a write edge; the host keeps the enable high before it
  wire logic drive = (cyc_q == SSWD_READ) && !out_enable_n_in;
  assign data_out = rd_q;
  assign data_oe_n_out = {(`SSWD_LANES*W){!drive}};
  assign lane_write_out = lanes_wr;
  assign sleeping_out = sleep_q;

  // checks
  // burst continuations, stepped or held, outside sleep
  sequence s_burst_advance;
    cont && !burst_advance_n_in && !sleep_q;
  endsequence
  sequence s_burst_hold;
    cont && burst_advance_n_in && !sleep_q;
  endsequence
  // sleep request seen on two edges in a row
  sequence s_sleep_held;
    sleep_request_in ##1 sleep_request_in;
  endsequence

  AST_WRITE_DECODE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (do_write && !global_write_n_in) |-> (lane_write_out == `SSWD_LANES_ALL))
    else $error("global write did not write all lanes");
  AST_READ_NO_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (global_write_n_in && byte_write_gate_n_in) |-> (lane_write_out == `SSWD_LANES_IDLE))
    else $error("write issued with strobes inactive");
  AST_LANE_SELECT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (do_write && global_write_n_in) |-> (lane_write_out == ~lane_n))
    else $error("wrong lanes written");
  AST_PROC_READ: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (proc_start && !sleep_q) |=> (cyc_q == SSWD_READ))
    else $error("proc strobe did not start a read");
  AST_WRITE_AFTER: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (lane_write_out != `SSWD_LANES_IDLE) |-> (ctrl_start || active_q))
    else $error("write without prior strobe");
  AST_OE_MASK: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cyc_q == SSWD_WRITE) |-> (&data_oe_n_out))
    else $error("pins driven during write");
  AST_DRIVE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (cyc_q == SSWD_READ && !out_enable_n_in) |-> (~|data_oe_n_out))
    else $error("read not driven");
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_burst_hold |=> (cnt_q == $past(cnt_q)))
    else $error("burst moved while held");
  AST_SLEEP: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    $rose(sleep_meta_q) ##1 sleep_meta_q |-> sleeping_out)
    else $error("sleep not entered in two cycles");
  // an advancing continuation moves the count by one, wrapping after four beats
  AST_ADVANCE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_burst_advance |=> (cnt_q == $past(cnt_q) + `SSWD_BURST_BITS'(1)))
    else $error("burst did not advance");
  // global write on a ctrl start writes every lane
  AST_CTRL_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (ctrl_start && !global_write_n_in && !sleep_q) |-> (lane_write_out == `SSWD_LANES_ALL))
    else $error("ctrl start write not taken");
  // the proc strobe never writes, whatever the write strobes say
  AST_PROC_NO_WRITE: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    proc_start |-> (lane_write_out == `SSWD_LANES_IDLE))
    else $error("write on proc strobe start");
  // a write edge makes the next cycle a write cycle, where the enable is masked
  AST_WRITE_MASKED: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    (lane_write_out != `SSWD_LANES_IDLE) |=> (cyc_q == SSWD_WRITE))
    else $error("write edge not followed by a write cycle");
  // pins float unless a read cycle has the enable low
  AST_FLOAT: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    ((cyc_q != SSWD_READ) || out_enable_n_in) |-> (&data_oe_n_out))
    else $error("pins driven outside an enabled read");
  // two sampled edges of request put the block to sleep
  AST_SLEEP_ENTRY: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    s_sleep_held |=> sleeping_out)
    else $error("sleep not entered after two edges");
  // asleep: no lane written, and pins float from the next cycle on
  AST_SLEEP_QUIET: assert property (@(posedge clk_in) disable iff (!rst_b_in)
    sleeping_out |-> (lane_write_out == `SSWD_LANES_IDLE) ##1 (&data_oe_n_out))
    else $error("activity while asleep");
endmodule : sswd_core

// file: sswd_host.sv
/* host side of the shared data pins.
   assumes one clock and no pull on the pins. */
`timescale 1ns/1ps
module sswd_host #(parameter int W = 36) (
  // clock
  input wire logic clk_in,
  // pins
  input wire logic [W-1:0] dev_data_in,
  input wire logic [W-1:0] dev_oe_n_in,
  input wire logic [W-1:0] host_data_in,
  input wire logic host_drive_in,
  output logic [W-1:0] wire_out
);
  logic [W-1:0] last_q = '0;
  // device wins where it drives, undriven bits toggle every cycle
  assign wire_out = (dev_oe_n_in & (host_drive_in ? host_data_in : ~last_q)) | (~dev_oe_n_in & dev_data_in);
  // remembers the wire level
  always_ff @(posedge clk_in) last_q <= wire_out;
endmodule : sswd_host

// file: sync_sram_write_decode_oe_bench.sv
/* bench for sswd_core against a memory model.
   assumes sswd_host resolves the data wire. */
`timescale 1ns/1ps
`include "sswd_cfg.svh"
module sync_sram_write_decode_oe_bench
  import sswd_pkg::*;
;
  localparam int W = `SSWD_LANES*(`SSWD_LANE_BITS+1);
  logic clk_in = 0, rst_b_in = 0, cs_n = 1, ps_n = 1, cc_n = 1, adv_n = 1;
  logic mode = 1, slp = 0, gw_n = 1, bwe_n = 1, oe_n = 1, drv = 0, asleep;
  logic [3:0] bw_n = 4'hf;
  logic [16:0] addr = 17'h0_0000;
  logic [W-1:0] hd = 36'h0_0000_0000, din, dout, doe_n;
  sswd_lane_t lw;
  int failures = 0, checks_done = 0;
  logic [W-1:0] mem [int];
  logic [31:0] rng = 32'hd7f2_afe9;
  sswd_core u_dut (.clk_in, .rst_b_in, .addr_in(addr), .chip_select_n_in(cs_n),
    .proc_addr_strobe_n_in(ps_n), .ctrl_addr_strobe_n_in(cc_n), .burst_advance_n_in(adv_n),
    .burst_mode_in(mode), .sleep_request_in(slp), .global_write_n_in(gw_n), .byte_write_gate_n_in(bwe_n),
    .lane_a_write_n_in(bw_n[0]), .lane_b_write_n_in(bw_n[1]), .lane_c_write_n_in(bw_n[2]),
    .lane_d_write_n_in(bw_n[3]), .out_enable_n_in(oe_n), .data_in(din), .data_out(dout),
    .data_oe_n_out(doe_n), .lane_write_out(lw), .sleeping_out(asleep));
  sswd_host #(.W(W)) u_host (.clk_in, .dev_data_in(dout), .dev_oe_n_in(doe_n), .host_data_in(hd),
    .host_drive_in(drv), .wire_out(din));
  // free running clock
  initial forever #10 clk_in = ~clk_in;
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs
  task automatic tick();
    @(posedge clk_in);
    #1;
  endtask : tick
  task automatic chk(string n, logic [W-1:0] e, logic [W-1:0] g);
    checks_done++;
    if (e !== g) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic idle();
    {ps_n, cc_n, cs_n, adv_n, gw_n, bwe_n, bw_n, drv} = 11'h7fe; // host releases the data wire
  endtask : idle
  // write started by the controller strobe, output enable held high first
  task automatic wr(logic [16:0] a, logic g, logic e, logic [3:0] b, logic [W-1:0] d);
    logic [3:0] x;
    x = !g ? 4'hf : !e ? ~b : 4'h0;
    {cc_n, cs_n, addr, gw_n, bwe_n, bw_n, hd, drv, oe_n} = {2'b00, a, g, e, b, d, 2'b11};
    #1 chk("lane_write", x, lw);
    for (int i = 0; i < 4; i++) if (x[i]) mem[a][9*i +: 9] = d[9*i +: 9];
    tick();
    idle();
    oe_n = 0;
    #1 chk("oe_masked", {W{x != 4'h0}}, doe_n);
    tick();
  endtask : wr
  // read by the processor strobe with all write strobes low, then a burst
  task automatic rd(logic [16:0] a);
    logic [1:0] n;
    {ps_n, cs_n, addr, gw_n, bwe_n, bw_n, oe_n} = {2'b00, a, 7'h00};
    #1 chk("lane_write", 0, lw);
    tick();
    {ps_n, cs_n, gw_n, bwe_n, bw_n, adv_n} = 9'h1fe; // strobes off, advance on for the burst
    chk("read_data", mem[a], dout);
    chk("oe_drive", 0, doe_n);
    oe_n = 1;
    #1 chk("oe_float", '1, doe_n);
    for (int k = 1; k < 5; k++) begin
      if (k < 4) n = mode ? a[1:0] ^ 2'(k) : a[1:0] + 2'(k);
      else adv_n = 1;
      tick();
      chk("burst_data", mem[{a[16:2], n}], dout);
    end
  endtask : rd
  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  // main sequence: fill blocks, gated writes with lane codes 0 to 15, reads in both burst orders
  initial begin
    repeat (4) @(posedge clk_in);
    #1 rst_b_in = 1;
    chk("sleeping", 0, asleep);
    for (int b = 0; b < 8; b++) begin
      logic [16:0] base;
      base = 17'(xs()) & 17'h1_fffc;
      mode = b[0];
      for (int j = 0; j < 4; j++) wr(base + 17'(j), 1'b0, 1'(xs()), 4'(xs()), {4'(xs()), xs()});
      for (int j = 0; j < 4; j++) wr(base + 17'(xs() & 3), 1'b1, b > 5, 4'(b * 4 + j), {4'(xs()), xs()});
      rd(base + 17'(xs() & 3));
    end
    slp = 1;
    repeat (`SSWD_SLEEP_CYCLES + 1) tick();
    chk("sleeping", 1, asleep);
    {cc_n, cs_n, gw_n} = 3'b000;
    #1 chk("lane_write_asleep", 0, lw);
    end_of_test();
  end
  // watchdog
  initial begin
    #100000;
    failures++;
    end_of_test();
  end
endmodule : sync_sram_write_decode_oe_bench
